// ### dv/cmm_cpu_model.sv
// Purpose: CPU core stand-in issuing events, accesses and user-rights setup
// Assumes: Tasks are called just after a falling edge of mclk
// Notes:   Requests stay driven until the next event; every pulse lasts one cycle
`timescale 1ns/1ns

module cmm_cpu_model (
  // Clock
  input  wire logic             mclk,
  // Towards the block
  output cmm_pkg::cmm_evt_t     evt,
  output cmm_pkg::cmm_mmu_cfg_t mmu_cfg,
  output cmm_pkg::cmm_req_t     acc_req,
  output cmm_pkg::cmm_req_t     cp_req
);
  initial begin
    evt = '0;
    mmu_cfg = '0;
    acc_req = '0;
    cp_req = '0;
  end

  task automatic send_evt(input cmm_pkg::cmm_evt_t e);
    acc_req = '0;
    cp_req = '0;
    evt = e;
    @(negedge mclk);
    evt = '0;
  endtask : send_evt

  // Valid left high so back-to-back requests need no gap
  task automatic access(input cmm_pkg::cmm_req_t a, input cmm_pkg::cmm_req_t c);
    acc_req = a;
    cp_req = c;
    @(negedge mclk);
  endtask : access

  task automatic set_rights(input cmm_pkg::cmm_mmu_cfg_t c);
    mmu_cfg = c;
    @(negedge mclk);
    mmu_cfg = '0;
  endtask : set_rights
endmodule : cmm_cpu_model

// ### dv/cmm_top_bench.sv
// Purpose: Self-checking bench for mode tracking and access control
// Assumes: Expected modes and rights are tracked here, not read back
// Notes:   Random addresses lean on partition edges
`timescale 1ns/1ns
`include "cmm_defines.svh"

module cmm_top_bench;
  logic                  mclk;
  logic                  rst_n;
  logic                  test_off;
  logic                  rom_large;
  cmm_pkg::cmm_evt_t     evt;
  cmm_pkg::cmm_mmu_cfg_t mmu_cfg;
  cmm_pkg::cmm_req_t     acc_req;
  cmm_pkg::cmm_req_t     cp_req;
  cmm_pkg::cmm_rsp_t     acc_rsp;
  cmm_pkg::cmm_rsp_t     cp_rsp;
  cmm_pkg::cmm_mode_t    mode;
  logic                  super_sys;
  cmm_pkg::cmm_redir_t   redir;
  cmm_pkg::cmm_mode_t    cur;
  cmm_pkg::cmm_mmu_cfg_t c;
  cmm_pkg::cmm_req_t     q;
  logic [23:0]           mb;
  logic [23:0]           ml;
  logic                  mw;
  int                    n_mismatch;
  int                    checked;
  int                    cycles;
  int                    seed;
  int                    k;
  localparam logic [23:0] BND [12] = '{24'h000000, 24'h04B000, 24'h060000, 24'h080000, 24'h080200, 24'h080500,
                                       24'h094000, 24'h0A0000, 24'h0A0200, 24'h0A1600, 24'h0A2080, 24'h0B0000};

  cmm_top i_cmm_top (.mclk(mclk), .rst_n(rst_n), .test_off(test_off), .rom_large(rom_large), .evt(evt),
                     .mmu_cfg(mmu_cfg), .acc_req(acc_req), .acc_rsp(acc_rsp), .cp_req(cp_req), .cp_rsp(cp_rsp),
                     .mode(mode), .super_sys(super_sys), .redir(redir));
  cmm_cpu_model i_cmm_cpu_model (.mclk(mclk), .evt(evt), .mmu_cfg(mmu_cfg), .acc_req(acc_req), .cp_req(cp_req));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Hang guard, far above the roughly 800 cycles needed
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 10000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  function automatic logic ok_cpu(input cmm_pkg::cmm_mode_t m, input cmm_pkg::cmm_req_t r);
    logic app;
    logic sup;
    app = (r.addr < (rom_large ? `CMM_ROM_APP_HI_L : `CMM_ROM_APP_HI_S)) ||
          (r.addr >= `CMM_EE_APP_LO && r.addr < `CMM_EE_HI) || (r.addr >= `CMM_RAM_GP_LO && r.addr < `CMM_RAM_HI);
    sup = (r.addr >= `CMM_ROM_TST_LO && r.addr < `CMM_EE_APP_LO) ||
          (r.addr >= `CMM_RAM_FW_LO && r.addr < `CMM_RAM_GP_LO);
    case (m)
      cmm_pkg::CMM_TEST: ok_cpu = app || sup;
      cmm_pkg::CMM_SYS:  ok_cpu = app;
      cmm_pkg::CMM_USR:  ok_cpu = app && r.addr >= mb && r.addr < ml && (mw || !r.write);
      default:           ok_cpu = sup;
    endcase
  endfunction : ok_cpu

  function automatic cmm_pkg::cmm_rsp_t exp_rsp(input logic ok, input cmm_pkg::cmm_req_t r);
    exp_rsp.grant = ok;
    exp_rsp.fault = !ok;
    exp_rsp.write = ok && r.write;
    exp_rsp.addr  = ok ? r.addr : 24'h000000;
  endfunction : exp_rsp

  function automatic cmm_pkg::cmm_req_t rnd_req();
    rnd_req.valid = 1'b1;
    rnd_req.write = 1'($random(seed));
    if ($random(seed) % 2)
      rnd_req.addr = BND[{$random(seed)} % 12] - {23'h000000, 1'($random(seed))};
    else
      rnd_req.addr = 24'({$random(seed)} % 32'h000B0000);
  endfunction : rnd_req

  function automatic cmm_pkg::cmm_evt_t ev(input int kind, input int idx);
    ev = '0;
    ev.boot_done   = (kind == 0);
    ev.exc_valid   = (kind == 1);
    ev.fcall_valid = (kind == 2);
    ev.scall_valid = (kind == 3);
    ev.drop        = (kind == 4);
    ev.exc_idx     = idx[4:0];
    ev.fcall_idx   = idx[2:0];
    ev.scall_idx   = idx[4:0];
  endfunction : ev

  function automatic void exp_next(input cmm_pkg::cmm_mode_t m, input cmm_pkg::cmm_evt_t e,
                                   output cmm_pkg::cmm_mode_t nm, output cmm_pkg::cmm_redir_t r);
    nm = m;
    r = '0;
    if (e.boot_done && m == cmm_pkg::CMM_BOOT) begin
      nm = test_off ? cmm_pkg::CMM_SYS : cmm_pkg::CMM_TEST;
    end else if (e.exc_valid) begin
      r = {1'b1, `CMM_EXC_VEC_BASE + {17'h00000, e.exc_idx, 2'h0}};
      if (m == cmm_pkg::CMM_USR) nm = cmm_pkg::CMM_SYS;
    end else if (e.fcall_valid && (m == cmm_pkg::CMM_SYS || m == cmm_pkg::CMM_USR)) begin
      nm = cmm_pkg::CMM_FW;
      r = {1'b1, `CMM_FIRMWARE_CALL_VECTOR_BASE + {19'h00000, e.fcall_idx, 2'h0}};
    end else if (e.scall_valid && m != cmm_pkg::CMM_BOOT && m != cmm_pkg::CMM_TEST) begin
      nm = cmm_pkg::CMM_SYS;
      r = {1'b1, `CMM_SYSTEM_CALL_VECTOR_BASE + {17'h00000, e.scall_idx, 2'h0}};
    end else if (e.drop && m == cmm_pkg::CMM_FW) begin
      nm = cmm_pkg::CMM_SYS;
    end else if (e.drop && m == cmm_pkg::CMM_SYS) begin
      nm = cmm_pkg::CMM_USR;
    end
  endfunction : exp_next

  task automatic chk_rsp(input string nm, input cmm_pkg::cmm_rsp_t e, input cmm_pkg::cmm_rsp_t g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_rsp

  task automatic chk_flow(input cmm_pkg::cmm_mode_t m, input cmm_pkg::cmm_redir_t r);
    logic [28:0] e;
    logic [28:0] g;
    e = {m, m == cmm_pkg::CMM_BOOT || m == cmm_pkg::CMM_TEST || m == cmm_pkg::CMM_FW, r};
    g = {mode, super_sys, redir.valid, r.valid ? redir.addr : 24'h000000};
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected mode_flow expected %h seen %h", e, g);
    end
  endtask : chk_flow

  task automatic do_acc(input int n);
    cmm_pkg::cmm_req_t a;
    cmm_pkg::cmm_req_t p;
    repeat (n) begin
      a = rnd_req();
      p = rnd_req();
      i_cmm_cpu_model.access(a, p);
      chk_rsp("cpu_rsp", exp_rsp(ok_cpu(cur, a), a), acc_rsp);
      chk_rsp("cp_rsp", exp_rsp(p.addr >= `CMM_RAM_CP_LO && p.addr < `CMM_RAM_HI, p), cp_rsp);
    end
  endtask : do_acc

  // Redirect is checked in its cycle, then must be gone one cycle later
  task automatic step(input cmm_pkg::cmm_evt_t e);
    cmm_pkg::cmm_mode_t  nm;
    cmm_pkg::cmm_redir_t r;
    exp_next(cur, e, nm, r);
    i_cmm_cpu_model.send_evt(e);
    chk_flow(nm, r);
    @(negedge mclk);
    cur = nm;
    chk_flow(nm, '0);
  endtask : step

  task automatic rights(input cmm_pkg::cmm_mmu_cfg_t x);
    i_cmm_cpu_model.set_rights(x);
    if (cur == cmm_pkg::CMM_SYS) begin
      mb = x.base;
      ml = x.limit;
      mw = x.wr_ok;
    end
  endtask : rights

  task automatic do_reset(input logic toff);
    @(negedge mclk);
    rst_n = 1'b0;
    test_off = toff;
    repeat (4) @(negedge mclk);
    chk_flow(cmm_pkg::CMM_BOOT, '0);
    rst_n = 1'b1;
    cur = cmm_pkg::CMM_BOOT;
    mb = 24'h000000;
    ml = 24'h000000;
    mw = 1'b0;
    @(negedge mclk);
  endtask : do_reset

  task automatic print_verdict();
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict

  initial begin
    seed = 37;
    n_mismatch = 0;
    checked = 0;
    cycles = 0;
    rst_n = 1'b0;
    test_off = 1'b0;
    rom_large = 1'b0;
    do_reset(1'b0);
    do_acc(8);
    step(ev(0, 0));
    do_acc(40);
    // Exception redirects; calls and drop refused in test mode
    for (k = 1; k < 5; k++) step(ev(k, k * 7));
    do_reset(1'b1);
    step(ev(0, 0));
    for (k = 0; k < 8; k++) begin
      step(ev(2, k));
      do_acc(4);
      step(ev(2, k));
      step(ev(k % 2 ? 3 : 4, k));
    end
    for (k = 0; k < 32; k++) step(ev(3, k));
    for (k = 0; k < 2; k++) begin
      rom_large = k[0];
      do_acc(40);
    end
    for (k = 0; k < 4; k++) begin
      q = rnd_req();
      c = {1'b1, 1'($random(seed)), q.addr, 24'h000000};
      c.limit = (k == 0) ? `CMM_RAM_HI : c.base + 24'({$random(seed)} % 32'h00030000);
      rights(c);
      step(ev(4, 0));
      do_acc(30);
      c.limit = `CMM_RAM_HI;
      rights(c);
      do_acc(10);
      step(ev(1, k + 20));
    end
    repeat (80) begin
      step(($random(seed) % 3 == 0) ? cmm_pkg::cmm_evt_t'(18'($random(seed))) :
                                      ev({$random(seed)} % 5, $random(seed)));
      do_acc(2);
    end
    print_verdict();
  end
endmodule : cmm_top_bench

// ### hw/cmm_defines.svh
// Purpose: Constants for CPU mode and memory access control
// Assumes: 24-bit byte address space, one flat map
// Notes:   Bounds are lower inclusive, upper exclusive
`ifndef CMM_DEFINES_SVH
`define CMM_DEFINES_SVH

`define CMM_AW            24
// ROM: application low, test ROM in the top 128 kB
`define CMM_ROM_APP_LO    24'h000000
`define CMM_ROM_APP_HI_S  24'h04B000
`define CMM_ROM_APP_HI_L  24'h060000
`define CMM_ROM_TST_LO    24'h060000
`define CMM_ROM_TST_HI    24'h080000
// EEPROM: 512 B manufacturer, 768 B firmware, rest application
`define CMM_EE_MAN_LO     24'h080000
`define CMM_EE_FW_LO      24'h080200
`define CMM_EE_APP_LO     24'h080500
`define CMM_EE_HI         24'h094000
// RAM: 512 B firmware, 5.0 kB general, 2.625 kB coprocessor
`define CMM_RAM_FW_LO     24'h0A0000
`define CMM_RAM_GP_LO     24'h0A0200
`define CMM_RAM_CP_LO     24'h0A1600
`define CMM_RAM_HI        24'h0A2080
// Vector tables, one word per entry
`define CMM_EXC_VEC_BASE  24'h000000
`define CMM_SYSTEM_CALL_VECTOR_BASE     24'h000100
`define CMM_FIRMWARE_CALL_VECTOR_BASE     24'h060000
// Reset values
`define CMM_MMU_BASE_RST  24'h000000
`define CMM_MMU_LIM_RST   24'h000000

`endif

// ### hw/cmm_pkg.sv
// Purpose: Types and helper functions for the mode/access block
// Assumes: cmm_defines.svh supplies the address width
// Notes:   Mode and region codes are fixed binary
`include "cmm_defines.svh"

package cmm_pkg;

  typedef enum logic [2:0] {
    CMM_BOOT = 3'h0,
    CMM_TEST = 3'h1,
    CMM_FW   = 3'h2,
    CMM_SYS  = 3'h3,
    CMM_USR  = 3'h4
  } cmm_mode_t;

  typedef enum logic [3:0] {
    CMM_RG_APP_ROM = 4'h0,
    CMM_RG_TST_ROM = 4'h1,
    CMM_RG_EE_MAN  = 4'h2,
    CMM_RG_EE_FW   = 4'h3,
    CMM_RG_EE_APP  = 4'h4,
    CMM_RG_RAM_FW  = 4'h5,
    CMM_RG_RAM_GP  = 4'h6,
    CMM_RG_RAM_CP  = 4'h7,
    CMM_RG_NONE    = 4'h8
  } cmm_region_t;

  typedef struct packed {
    logic               valid;
    logic               write;
    logic [`CMM_AW-1:0] addr;
  } cmm_req_t;

  typedef struct packed {
    logic               grant;
    logic               fault;
    logic               write;
    logic [`CMM_AW-1:0] addr;
  } cmm_rsp_t;

  typedef struct packed {
    logic               valid;
    logic               wr_ok;
    logic [`CMM_AW-1:0] base;
    logic [`CMM_AW-1:0] limit;
  } cmm_mmu_cfg_t;

  typedef struct packed {
    logic       boot_done;
    logic       exc_valid;
    logic [4:0] exc_idx;
    logic       fcall_valid;
    logic [2:0] fcall_idx;
    logic       scall_valid;
    logic [4:0] scall_idx;
    logic       drop;
  } cmm_evt_t;

  typedef struct packed {
    logic               valid;
    logic [`CMM_AW-1:0] addr;
  } cmm_redir_t;

  function automatic logic in_win(input logic [`CMM_AW-1:0] a,
                                  input logic [`CMM_AW-1:0] lo,
                                  input logic [`CMM_AW-1:0] hi);
    in_win = (a >= lo) && (a < hi);
  endfunction : in_win

  function automatic logic [`CMM_AW-1:0] vec_addr(input logic [`CMM_AW-1:0] base,
                                                  input logic [4:0]         idx);
    vec_addr = base + {17'h00000, idx, 2'h0};
  endfunction : vec_addr

endpackage : cmm_pkg

// ### hw/cmm_region_dec.sv
// Purpose: Maps a byte address to its memory partition
// Assumes: Purely combinational, used by the CPU path
// Notes:   Gap between 300 kB and 384 kB is unmapped when small
`timescale 1ns/1ns
`include "cmm_defines.svh"

module cmm_region_dec (
  // Address in
  input  wire logic [`CMM_AW-1:0] addr,
  input  wire logic               rom_large,
  // Partition out
  output cmm_pkg::cmm_region_t    region
);

  logic [`CMM_AW-1:0] app_hi;

  always_comb begin
    app_hi = rom_large ? `CMM_ROM_APP_HI_L : `CMM_ROM_APP_HI_S;
    if (cmm_pkg::in_win(addr, `CMM_ROM_APP_LO, app_hi)) begin
      region = cmm_pkg::CMM_RG_APP_ROM;
    end else if (cmm_pkg::in_win(addr, `CMM_ROM_TST_LO, `CMM_ROM_TST_HI)) begin
      region = cmm_pkg::CMM_RG_TST_ROM;
    end else if (cmm_pkg::in_win(addr, `CMM_EE_MAN_LO, `CMM_EE_FW_LO)) begin
      region = cmm_pkg::CMM_RG_EE_MAN;
    end else if (cmm_pkg::in_win(addr, `CMM_EE_FW_LO, `CMM_EE_APP_LO)) begin
      region = cmm_pkg::CMM_RG_EE_FW;
    end else if (cmm_pkg::in_win(addr, `CMM_EE_APP_LO, `CMM_EE_HI)) begin
      region = cmm_pkg::CMM_RG_EE_APP;
    end else if (cmm_pkg::in_win(addr, `CMM_RAM_FW_LO, `CMM_RAM_GP_LO)) begin
      region = cmm_pkg::CMM_RG_RAM_FW;
    end else if (cmm_pkg::in_win(addr, `CMM_RAM_GP_LO, `CMM_RAM_CP_LO)) begin
      region = cmm_pkg::CMM_RG_RAM_GP;
    end else if (cmm_pkg::in_win(addr, `CMM_RAM_CP_LO, `CMM_RAM_HI)) begin
      region = cmm_pkg::CMM_RG_RAM_CP;
    end else begin
      region = cmm_pkg::CMM_RG_NONE;
    end
  end

endmodule : cmm_region_dec

// ### hw/cmm_top.sv
// Purpose: CPU mode tracking and per-mode memory access control
// Assumes: Inputs synchronous to mclk, answers one cycle later
// Notes:   Answers are registered one cycle after the request
// Behaviour
// - Track boot, test, firmware, system, user
// - Super system is always one of three sub-modes
// - Super sub-modes closed to customer software
// - Start-up ends in test before disable
// - Start-up ends in system after disable
// - Exceptions and interrupts jump to ROM vectors
// - Eight firmware call vectors enter firmware
// - Thirty-two system call vectors enter system
// - System mode reaches all application resources
// - User limited to rights system granted
// - Test mode accesses are unrestricted
// - Boot/firmware confined to dedicated partitions
// - Application memories for system and user
// - User rights configurable only in system
// - ROM: 300/384 kB application, 128 kB test
// - EEPROM reserves 512 B and 768 B
// - RAM reserves 512 B for firmware
// - Application RAM: general plus coprocessor part
// - Coprocessor reaches shared RAM only, no rights checks
`timescale 1ns/1ns
`include "cmm_defines.svh"

module cmm_top (
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                rst_n,
  // Configuration levels
  input  wire logic                test_off,
  input  wire logic                rom_large,
  // Mode change events
  input  cmm_pkg::cmm_evt_t        evt,
  // User rights setup
  input  cmm_pkg::cmm_mmu_cfg_t    mmu_cfg,
  // CPU access
  input  cmm_pkg::cmm_req_t        acc_req,
  output cmm_pkg::cmm_rsp_t        acc_rsp,
  // Coprocessor access
  input  cmm_pkg::cmm_req_t        cp_req,
  output cmm_pkg::cmm_rsp_t        cp_rsp,
  // Mode and program flow
  output cmm_pkg::cmm_mode_t       mode,
  output logic                     super_sys,
  output cmm_pkg::cmm_redir_t      redir
);

  cmm_pkg::cmm_mode_t   mode_reg,      mode_next;
  logic                 super_reg,     super_next;
  cmm_pkg::cmm_redir_t  redir_reg,     redir_next;
  logic                 test_off_reg;
  cmm_pkg::cmm_mmu_cfg_t mmu_reg,      mmu_next;
  cmm_pkg::cmm_rsp_t    acc_reg,       acc_next;
  cmm_pkg::cmm_rsp_t    cp_reg,        cp_next;
  cmm_pkg::cmm_region_t region;
  logic                 acc_ok;
  logic                 usr_ok;
  logic                 cp_in;

  cmm_region_dec u_dec (
    .addr      (acc_req.addr),
    .rom_large (rom_large),
    .region    (region)
  );

  // Strap followed from reset release; reset value keeps test closed
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      test_off_reg <= 1'b1;
    end else begin
      test_off_reg <= test_off;
    end
  end

  // Mode sequencing, highest priority first
  always_comb begin
    mode_next  = mode_reg;
    redir_next = '0;
    if (evt.boot_done && mode_reg == cmm_pkg::CMM_BOOT) begin
      mode_next = test_off_reg ? cmm_pkg::CMM_SYS : cmm_pkg::CMM_TEST;
    // fixed ROM vector, never a call vector
    end else if (evt.exc_valid) begin
      redir_next.valid = 1'b1;
      redir_next.addr  = cmm_pkg::vec_addr(`CMM_EXC_VEC_BASE, evt.exc_idx);
      if (mode_reg == cmm_pkg::CMM_USR) begin
        mode_next = cmm_pkg::CMM_SYS;
      end
    // firmware entry only from embedded modes
    end else if (evt.fcall_valid &&
                 (mode_reg == cmm_pkg::CMM_SYS || mode_reg == cmm_pkg::CMM_USR)) begin
      mode_next        = cmm_pkg::CMM_FW;
      redir_next.valid = 1'b1;
      redir_next.addr  = cmm_pkg::vec_addr(`CMM_FIRMWARE_CALL_VECTOR_BASE, {2'h0, evt.fcall_idx});
    end else if (evt.scall_valid &&
                 (mode_reg == cmm_pkg::CMM_SYS || mode_reg == cmm_pkg::CMM_USR ||
                  mode_reg == cmm_pkg::CMM_FW)) begin
      mode_next        = cmm_pkg::CMM_SYS;
      redir_next.valid = 1'b1;
      redir_next.addr  = cmm_pkg::vec_addr(`CMM_SYSTEM_CALL_VECTOR_BASE, evt.scall_idx);
    end else if (evt.drop) begin
      unique case (mode_reg)
        cmm_pkg::CMM_FW:   mode_next = cmm_pkg::CMM_SYS;
        cmm_pkg::CMM_SYS:  mode_next = cmm_pkg::CMM_USR;
        cmm_pkg::CMM_BOOT,
        cmm_pkg::CMM_TEST,
        cmm_pkg::CMM_USR:  mode_next = mode_reg;
        // Corrupted code falls back to the most closed mode
        default:           mode_next = cmm_pkg::CMM_BOOT;
      endcase
    end
    if (mode_next > cmm_pkg::CMM_USR) begin
      mode_next = cmm_pkg::CMM_BOOT;
    end
    super_next = (mode_next == cmm_pkg::CMM_BOOT) || (mode_next == cmm_pkg::CMM_TEST) ||
                 (mode_next == cmm_pkg::CMM_FW);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg  <= cmm_pkg::CMM_BOOT;
      super_reg <= 1'b1;
      redir_reg <= '0;
    end else begin
      mode_reg  <= mode_next;
      super_reg <= super_next;
      redir_reg <= redir_next;
    end
  end

  always_comb begin
    mmu_next       = mmu_reg;
    mmu_next.valid = 1'b0;
    if (mmu_cfg.valid && mode_reg == cmm_pkg::CMM_SYS) begin
      mmu_next       = mmu_cfg;
      mmu_next.valid = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mmu_reg.valid <= 1'b0;
      mmu_reg.wr_ok <= 1'b0;
      mmu_reg.base  <= `CMM_MMU_BASE_RST;
      mmu_reg.limit <= `CMM_MMU_LIM_RST;
    end else begin
      mmu_reg <= mmu_next;
    end
  end

  // Access rights per mode
  always_comb begin
    usr_ok = cmm_pkg::in_win(acc_req.addr, mmu_reg.base, mmu_reg.limit) &&
             (mmu_reg.wr_ok || !acc_req.write);
    acc_ok = 1'b0;
    unique case (mode_reg)
      cmm_pkg::CMM_TEST: acc_ok = (region != cmm_pkg::CMM_RG_NONE);
      cmm_pkg::CMM_BOOT,
      cmm_pkg::CMM_FW:   acc_ok = (region == cmm_pkg::CMM_RG_TST_ROM) ||
                                  (region == cmm_pkg::CMM_RG_EE_MAN)  ||
                                  (region == cmm_pkg::CMM_RG_EE_FW)   ||
                                  (region == cmm_pkg::CMM_RG_RAM_FW);
      cmm_pkg::CMM_SYS:  acc_ok = (region == cmm_pkg::CMM_RG_APP_ROM) ||
                                  (region == cmm_pkg::CMM_RG_EE_APP)  ||
                                  (region == cmm_pkg::CMM_RG_RAM_GP)  ||
                                  (region == cmm_pkg::CMM_RG_RAM_CP);
      cmm_pkg::CMM_USR:  acc_ok = usr_ok && ((region == cmm_pkg::CMM_RG_APP_ROM) ||
                                  (region == cmm_pkg::CMM_RG_EE_APP)  ||
                                  (region == cmm_pkg::CMM_RG_RAM_GP)  ||
                                  (region == cmm_pkg::CMM_RG_RAM_CP));
      default:           acc_ok = 1'b0;
    endcase
    acc_next.grant = acc_req.valid && acc_ok;
    acc_next.fault = acc_req.valid && !acc_ok;
    acc_next.write = acc_req.valid && acc_ok && acc_req.write;
    acc_next.addr  = acc_ok ? acc_req.addr : '0;
    // shared RAM only, no rights check
    cp_in          = cmm_pkg::in_win(cp_req.addr, `CMM_RAM_CP_LO, `CMM_RAM_HI);
    cp_next.grant  = cp_req.valid && cp_in;
    cp_next.fault  = cp_req.valid && !cp_in;
    cp_next.write  = cp_req.valid && cp_in && cp_req.write;
    cp_next.addr   = cp_in ? cp_req.addr : '0;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg <= '0;
      cp_reg  <= '0;
    end else begin
      acc_reg <= acc_next;
      cp_reg  <= cp_next;
    end
  end

  assign mode      = mode_reg;
  assign super_sys = super_reg;
  assign redir     = redir_reg;
  assign acc_rsp   = acc_reg;
  assign cp_rsp    = cp_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  logic boot_exit;
  logic exc_win;
  assign boot_exit = evt.boot_done && mode_reg == cmm_pkg::CMM_BOOT;
  assign exc_win   = evt.exc_valid && !boot_exit;

  property p_five_modes;
    mode_reg inside {cmm_pkg::CMM_BOOT, cmm_pkg::CMM_TEST, cmm_pkg::CMM_FW,
                     cmm_pkg::CMM_SYS, cmm_pkg::CMM_USR};
  endproperty
  a_five_modes: assert property (p_five_modes) else $error("mode code illegal");

  property p_super;
    super_reg == (mode_reg inside {cmm_pkg::CMM_BOOT, cmm_pkg::CMM_TEST, cmm_pkg::CMM_FW});
  endproperty
  a_super: assert property (p_super) else $error("super flag disagrees with mode");

  property p_no_cust_ss;
    (mode_reg inside {cmm_pkg::CMM_SYS, cmm_pkg::CMM_USR}) && !evt.fcall_valid
      |=> mode_reg inside {cmm_pkg::CMM_SYS, cmm_pkg::CMM_USR};
  endproperty
  a_no_cust_ss: assert property (p_no_cust_ss) else $error("super mode entered without call");

  property p_boot_test;
    boot_exit && !test_off_reg |=> mode_reg == cmm_pkg::CMM_TEST && super_reg;
  endproperty
  a_boot_test: assert property (p_boot_test) else $error("start-up did not end in test");

  property p_boot_sys;
    boot_exit && test_off_reg |=> mode_reg == cmm_pkg::CMM_SYS && !super_reg;
  endproperty
  a_boot_sys: assert property (p_boot_sys) else $error("start-up did not end in system");

  property p_exc_vec;
    exc_win |=> redir_reg.valid &&
      redir_reg.addr == cmm_pkg::vec_addr(`CMM_EXC_VEC_BASE, $past(evt.exc_idx));
  endproperty
  a_exc_vec: assert property (p_exc_vec) else $error("exception vector wrong");

  property p_fcall;
    evt.fcall_valid && !evt.exc_valid && !boot_exit &&
    (mode_reg inside {cmm_pkg::CMM_SYS, cmm_pkg::CMM_USR})
      |=> mode_reg == cmm_pkg::CMM_FW && redir_reg.valid &&
          redir_reg.addr == cmm_pkg::vec_addr(`CMM_FIRMWARE_CALL_VECTOR_BASE, {2'h0, $past(evt.fcall_idx)});
  endproperty
  a_fcall: assert property (p_fcall) else $error("firmware call not taken");

  property p_scall;
    evt.scall_valid && !evt.exc_valid && !evt.fcall_valid && (mode_reg == cmm_pkg::CMM_FW)
      |=> mode_reg == cmm_pkg::CMM_SYS &&
          redir_reg.addr == cmm_pkg::vec_addr(`CMM_SYSTEM_CALL_VECTOR_BASE, $past(evt.scall_idx));
  endproperty
  a_scall: assert property (p_scall) else $error("system call not taken");

  property p_exc_no_fw;
    exc_win && mode_reg != cmm_pkg::CMM_FW |=> mode_reg != cmm_pkg::CMM_FW;
  endproperty
  a_exc_no_fw: assert property (p_exc_no_fw) else $error("event entered firmware");

  property p_test_free;
    acc_req.valid && mode_reg == cmm_pkg::CMM_TEST && region != cmm_pkg::CMM_RG_NONE
      |=> acc_reg.grant && !acc_reg.fault;
  endproperty
  a_test_free: assert property (p_test_free) else $error("test access refused");

  property p_ss_conf;
    acc_req.valid && (mode_reg inside {cmm_pkg::CMM_BOOT, cmm_pkg::CMM_FW}) &&
    (region inside {cmm_pkg::CMM_RG_APP_ROM, cmm_pkg::CMM_RG_EE_APP, cmm_pkg::CMM_RG_RAM_GP})
      |=> acc_reg.fault && !acc_reg.grant;
  endproperty
  a_ss_conf: assert property (p_ss_conf) else $error("firmware reached application memory");

  property p_sys_app;
    acc_req.valid && mode_reg == cmm_pkg::CMM_SYS &&
    (region inside {cmm_pkg::CMM_RG_RAM_GP, cmm_pkg::CMM_RG_RAM_CP})
      |=> acc_reg.grant && !acc_reg.fault;
  endproperty
  a_sys_app: assert property (p_sys_app) else $error("system denied application RAM");

  property p_user_mmu;
    acc_req.valid && mode_reg == cmm_pkg::CMM_USR && !usr_ok |=> acc_reg.fault && acc_reg.addr == '0;
  endproperty
  a_user_mmu: assert property (p_user_mmu) else $error("user passed outside its rights");

  property p_cfg_sys;
    mmu_cfg.valid && mode_reg != cmm_pkg::CMM_SYS |=> $stable(mmu_reg);
  endproperty
  a_cfg_sys: assert property (p_cfg_sys) else $error("rights changed outside system");

  property p_cp;
    cp_req.valid |=> cp_reg.grant == $past(cp_in) && cp_reg.fault == !$past(cp_in);
  endproperty
  a_cp: assert property (p_cp) else $error("coprocessor check wrong");

  property p_fault;
    acc_req.valid && !acc_ok |=> acc_reg.fault && !acc_reg.grant && !acc_reg.write;
  endproperty
  a_fault: assert property (p_fault) else $error("denied access not suppressed");

  c_boot_test: cover property (boot_exit && !test_off_reg ##1 mode_reg == cmm_pkg::CMM_TEST);
  c_fw_call:   cover property (mode_reg == cmm_pkg::CMM_USR ##1 mode_reg == cmm_pkg::CMM_FW);
  c_usr_fault: cover property (acc_req.valid && mode_reg == cmm_pkg::CMM_USR ##1 acc_reg.fault);
  c_cp_grant:  cover property (cp_reg.grant);

endmodule : cmm_top
